//--- hdl/cpu_regs_pkg.sv
package cpu_regs_pkg;

  // stack geometry
  localparam logic [15:0] STACK_RESET_VAL  = 16'h01FF;
  localparam logic [8:0]  STACK_UPPER_BITS = 9'h003;
  localparam int          STACK_LOW_BITS   = 7;

  // condition flag bit positions
  localparam int FLAG_CARRY_POS = 0;
  localparam int FLAG_ZERO_POS  = 1;
  localparam int FLAG_NEG_POS   = 2;
  localparam int FLAG_MASK_POS  = 3;
  localparam int FLAG_HALF_POS  = 4;

  // reset value of flags: top three ones, mask set, undefined bits taken as zero
  localparam logic [7:0] FLAGS_RESET_VAL = 8'hE8;
  localparam logic [7:0] FLAGS_FIXED_ONE = 8'hE0;

  // interrupt context length and subroutine frame length
  localparam logic [2:0] CTX_BYTES  = 3'h5;
  localparam logic [2:0] CALL_BYTES = 3'h2;

  // register selector for the sequencer's write and read port
  typedef enum logic [2:0] {
    SEL_ACC   = 3'b000,
    SEL_IDX1  = 3'b001,
    SEL_IDX2  = 3'b010,
    SEL_PCL   = 3'b011,
    SEL_PCH   = 3'b100,
    SEL_FLAGS = 3'b101,
    SEL_SPL   = 3'b110
  } reg_sel_t;

  // stack operation requested by the sequencer
  typedef enum logic [2:0] {
    STK_NONE    = 3'b000,
    STK_PUSH    = 3'b001,
    STK_POP     = 3'b010,
    STK_IRQ     = 3'b011,
    STK_INTERRUPT_RETURN_INSTR    = 3'b100,
    STK_RESETSP = 3'b101
  } stack_op_t;

  // context sequencer states
  typedef enum logic [1:0] {
    CTX_IDLE = 2'b00,
    CTX_SAVE = 2'b01,
    CTX_REST = 2'b10
  } ctx_state_t;

endpackage

//--- hdl/cpu_register_set_flags_stack.sv
// Summary of operation
// - eight-bit accumulator holds operands and results.
// - two eight-bit index registers for addressing or temporary data.
// - second index register is never saved or restored on interrupts.
// - sixteen-bit program counter made of low and high bytes.
// - registers are not memory mapped; only dedicated ports reach them.
// - eight-bit flags, top three read one, reset with mask set.
// - half carry bit 4 follows carry out of bit 3 on adds.
// - mask bit 3 set on interrupt entry or software, only software or interrupt return clears.
// - requests during mask are held pending until mask clears.
// - interrupt return restores the saved flags, mask bit as it was at entry.
// - clearing mask inside a handler lets pending requests through regardless.
// - negative bit 2 copies result bit 7.
// - zero bit 1 set when result is zero.
// - carry bit 0 from arithmetic, set/clear instructions, shifts and bit tests.
// - flags byte can be pushed and popped.
// - stack pointer points to next free byte; post-decrement push, pre-increment pop.
// - upper nine bits fixed; reset or reset instruction loads 01FF.
// - stack pointer wraps silently at either limit.
// - stack pointer low byte loadable and readable.
// - interrupt entry stores program counter low byte first.
// - call uses two stack bytes, interrupt uses five.
`timescale 1ns/1ps
module cpu_register_set_flags_stack
  import cpu_regs_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // register write port from the sequencer
  input  wire logic        wr_en,
  input  wire reg_sel_t    wr_sel,
  input  wire logic [7:0]  wr_data,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_load_val,
  input  wire logic        pc_inc,
  // arithmetic unit result and flag updates
  input  wire logic        alu_valid,
  input  wire logic [7:0]  alu_result,
  input  wire logic        alu_upd_nz,
  input  wire logic        alu_upd_half,
  input  wire logic        alu_half,
  input  wire logic        alu_upd_carry,
  input  wire logic        alu_carry,
  // flag instructions
  input  wire logic        mask_set_instr,
  input  wire logic        mask_clear_instr,
  input  wire logic        carry_set_instr,
  input  wire logic        carry_clear_instr,
  // stack operations and memory side
  input  wire stack_op_t   stack_op,
  input  wire reg_sel_t    stack_sel,
  input  wire logic [7:0]  stack_rd_data,
  output logic             stack_wr_ff,
  output logic             stack_rd_ff,
  output logic [15:0]      stack_addr_ff,
  output logic [7:0]       stack_wr_data_ff,
  output logic             ctx_busy_ff,
  // interrupt requests
  input  wire logic        irq_req,
  output logic             irq_take_ff,
  // register views
  output logic [7:0]       accumulator_ff,
  output logic [7:0]       index_first_ff,
  output logic [7:0]       index_second_ff,
  output logic [15:0]      program_counter_ff,
  output logic [7:0]       condition_flags_ff,
  output logic [15:0]      stack_pointer_ff
);

  logic [6:0]  sp_low_ff;
  logic [4:0]  flag_bits_ff;
  logic        irq_pend_ff;
  ctx_state_t  ctx_state_ff;
  logic [2:0]  ctx_cnt_ff;
  logic        rd_pend_ff;
  reg_sel_t    rd_sel_ff;
  logic [6:0]  nxt_sp_low;
  logic [2:0]  nxt_step;
  logic        op_push;
  logic        op_pop;
  reg_sel_t    push_sel;
  reg_sel_t    ctx_sel;
  logic [7:0]  flags_view;
  logic [7:0]  push_byte;

  assign flags_view = FLAGS_FIXED_ONE | {3'h0, flag_bits_ff};
  assign nxt_step   = ctx_cnt_ff + 3'h1;

  // context slot order; return walks it backwards
  always_comb begin
    case (ctx_cnt_ff)
      3'h0:    ctx_sel = SEL_PCL;
      3'h1:    ctx_sel = SEL_PCH;
      3'h2:    ctx_sel = SEL_IDX1;
      3'h3:    ctx_sel = SEL_ACC;
      default: ctx_sel = SEL_FLAGS;
    endcase
  end

  // one push or pop byte per cycle; context uses the counter
  always_comb begin
    op_push  = (stack_op == STK_PUSH) && (ctx_state_ff == CTX_IDLE);
    op_pop   = (stack_op == STK_POP) && (ctx_state_ff == CTX_IDLE);
    push_sel = stack_sel;
    if (ctx_state_ff == CTX_SAVE) begin
      op_push  = 1'b1;
      push_sel = ctx_sel;
    end
    if (ctx_state_ff == CTX_REST) begin
      op_pop = 1'b1;
    end
  end

  // byte placed on the stack
  always_comb begin
    case (push_sel)
      SEL_ACC:   push_byte = accumulator_ff;
      SEL_IDX1:  push_byte = index_first_ff;
      SEL_IDX2:  push_byte = index_second_ff;
      SEL_PCL:   push_byte = program_counter_ff[7:0];
      SEL_PCH:   push_byte = program_counter_ff[15:8];
      SEL_FLAGS: push_byte = flags_view;
      default:   push_byte = {1'b0, sp_low_ff};
    endcase
  end

  // low bits wrap naturally in seven bits, no overflow flag exists
  always_comb begin
    nxt_sp_low = sp_low_ff;
    if (op_push) begin
      nxt_sp_low = sp_low_ff - 7'h01;
    end else if (op_pop) begin
      nxt_sp_low = sp_low_ff + 7'h01;
    end
  end

  // stack pointer low bits
  always_ff @(posedge ref_clk) begin
    if (reset || (stack_op == STK_RESETSP && ctx_state_ff == CTX_IDLE)) begin
      sp_low_ff <= STACK_RESET_VAL[STACK_LOW_BITS-1:0];
    end else if (wr_en && wr_sel == SEL_SPL) begin
      sp_low_ff <= wr_data[6:0];
    end else begin
      sp_low_ff <= nxt_sp_low;
    end
  end

  // memory strobes: push writes at current pointer, pop reads at pointer plus one
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stack_wr_ff      <= 1'b0;
      stack_rd_ff      <= 1'b0;
      stack_addr_ff    <= STACK_RESET_VAL;
      stack_wr_data_ff <= 8'h00;
    end else begin
      stack_wr_ff      <= op_push;
      stack_rd_ff      <= op_pop;
      stack_wr_data_ff <= push_byte;
      if (op_push) begin
        stack_addr_ff <= {STACK_UPPER_BITS, sp_low_ff};
      end else if (op_pop) begin
        stack_addr_ff <= {STACK_UPPER_BITS, nxt_sp_low};
      end
    end
  end

  // pop data arrives in the cycle the read strobe is high; remember where it goes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_pend_ff <= 1'b0;
      rd_sel_ff  <= SEL_ACC;
    end else begin
      rd_pend_ff <= op_pop;
      if (ctx_state_ff == CTX_REST) begin
        rd_sel_ff <= ctx_sel;
      end else begin
        rd_sel_ff <= stack_sel;
      end
    end
  end

  // context sequencer, five bytes each way
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctx_state_ff <= CTX_IDLE;
      ctx_cnt_ff   <= 3'h0;
      ctx_busy_ff  <= 1'b0;
      irq_take_ff  <= 1'b0;
    end else begin
      irq_take_ff <= 1'b0;
      case (ctx_state_ff)
        CTX_IDLE: begin
          if (stack_op == STK_IRQ || (irq_pend_ff && !flag_bits_ff[FLAG_MASK_POS])) begin
            ctx_state_ff <= CTX_SAVE;
            ctx_cnt_ff   <= 3'h0;
            ctx_busy_ff  <= 1'b1;
            irq_take_ff  <= 1'b1;
          end else if (stack_op == STK_INTERRUPT_RETURN_INSTR) begin
            ctx_state_ff <= CTX_REST;
            ctx_cnt_ff   <= CTX_BYTES - 3'h1;
            ctx_busy_ff  <= 1'b1;
          end
        end
        CTX_SAVE: begin
          ctx_cnt_ff <= nxt_step;
          if (nxt_step == CTX_BYTES) begin
            ctx_state_ff <= CTX_IDLE;
            ctx_busy_ff  <= 1'b0;
          end
        end
        CTX_REST: begin
          ctx_cnt_ff <= ctx_cnt_ff - 3'h1;
          if (ctx_cnt_ff == 3'h0) begin
            ctx_state_ff <= CTX_IDLE;
            ctx_busy_ff  <= 1'b0;
          end
        end
        default: begin
          ctx_state_ff <= CTX_IDLE;
          ctx_busy_ff  <= 1'b0;
        end
      endcase
    end
  end

  // pending request latch; a new request wins over the take
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_pend_ff <= 1'b0;
    end else if (irq_req) begin
      irq_pend_ff <= 1'b1;
    end else if (ctx_state_ff == CTX_IDLE && !flag_bits_ff[FLAG_MASK_POS]) begin
      irq_pend_ff <= 1'b0;
    end
  end

  // accumulator and first index: write port, stack pop, context restore; alu result to accumulator only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      accumulator_ff <= 8'h00;
      index_first_ff <= 8'h00;
    end else begin
      if (rd_pend_ff && rd_sel_ff == SEL_ACC) begin
        accumulator_ff <= stack_rd_data;
      end else if (wr_en && wr_sel == SEL_ACC) begin
        accumulator_ff <= wr_data;
      end else if (alu_valid) begin
        accumulator_ff <= alu_result;
      end
      if (rd_pend_ff && rd_sel_ff == SEL_IDX1) begin
        index_first_ff <= stack_rd_data;
      end else if (wr_en && wr_sel == SEL_IDX1) begin
        index_first_ff <= wr_data;
      end
    end
  end

  // second index is outside the interrupt context
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      index_second_ff <= 8'h00;
    end else if (rd_pend_ff && rd_sel_ff == SEL_IDX2 && ctx_state_ff == CTX_IDLE) begin
      index_second_ff <= stack_rd_data;
    end else if (wr_en && wr_sel == SEL_IDX2) begin
      index_second_ff <= wr_data;
    end
  end

  // program counter bytes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      program_counter_ff <= 16'h0000;
    end else if (rd_pend_ff && rd_sel_ff == SEL_PCL) begin
      program_counter_ff[7:0] <= stack_rd_data;
    end else if (rd_pend_ff && rd_sel_ff == SEL_PCH) begin
      program_counter_ff[15:8] <= stack_rd_data;
    end else if (pc_load) begin
      program_counter_ff <= pc_load_val;
    end else if (wr_en && wr_sel == SEL_PCL) begin
      program_counter_ff[7:0] <= wr_data;
    end else if (wr_en && wr_sel == SEL_PCH) begin
      program_counter_ff[15:8] <= wr_data;
    end else if (pc_inc) begin
      program_counter_ff <= program_counter_ff + 16'h0001;
    end
  end

  // flag bits; entry sets mask, only software or restore clears it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flag_bits_ff <= FLAGS_RESET_VAL[4:0];
    end else if (rd_pend_ff && rd_sel_ff == SEL_FLAGS) begin
      flag_bits_ff <= stack_rd_data[4:0];
    end else if (wr_en && wr_sel == SEL_FLAGS) begin
      flag_bits_ff <= wr_data[4:0];
    end else begin
      if (alu_valid && alu_upd_half) begin
        flag_bits_ff[FLAG_HALF_POS] <= alu_half;
      end
      if (ctx_state_ff == CTX_SAVE && nxt_step == CTX_BYTES) begin
        flag_bits_ff[FLAG_MASK_POS] <= 1'b1;
      end else if (mask_set_instr) begin
        flag_bits_ff[FLAG_MASK_POS] <= 1'b1;
      end else if (mask_clear_instr) begin
        flag_bits_ff[FLAG_MASK_POS] <= 1'b0;
      end
      if (alu_valid && alu_upd_nz) begin
        flag_bits_ff[FLAG_NEG_POS]  <= alu_result[7];
        flag_bits_ff[FLAG_ZERO_POS] <= (alu_result == 8'h00);
      end
      if (carry_set_instr) begin
        flag_bits_ff[FLAG_CARRY_POS] <= 1'b1;
      end else if (carry_clear_instr) begin
        flag_bits_ff[FLAG_CARRY_POS] <= 1'b0;
      end else if (alu_valid && alu_upd_carry) begin
        flag_bits_ff[FLAG_CARRY_POS] <= alu_carry;
      end
    end
  end

  // registered views; only dedicated ports reach these, no address map
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      condition_flags_ff <= FLAGS_RESET_VAL;
      stack_pointer_ff   <= STACK_RESET_VAL;
    end else begin
      condition_flags_ff <= flags_view;
      stack_pointer_ff   <= {STACK_UPPER_BITS, nxt_sp_low};
    end
  end

endmodule

//--- tb/cpu_regs_chk_sva.sv
`timescale 1ns/1ps
module cpu_regs_chk
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // requests
  input wire stack_op_t   stack_op,
  input wire logic        carry_set_instr,
  input wire logic        alu_valid,
  // stack side and views
  input wire logic        stack_wr_ff,
  input wire logic        stack_rd_ff,
  input wire logic [15:0] stack_addr_ff,
  input wire logic        ctx_busy_ff,
  input wire logic        irq_take_ff,
  input wire logic [7:0]  condition_flags_ff,
  input wire logic [15:0] stack_pointer_ff
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // five context bytes, then the strobe drops
  sequence save_burst;
    stack_wr_ff [*5] ##1 !stack_wr_ff;
  endsequence
  sequence next_free_top;
    ##[1:2] stack_pointer_ff == STACK_RESET_VAL;
  endsequence

  AST_FLAGS_TOP: assert property (condition_flags_ff[7:5] == 3'h7)
    else $error("flags top bits not ones");
  AST_SP_FIXED: assert property (stack_pointer_ff[15:7] == STACK_UPPER_BITS)
    else $error("stack pointer upper bits moved");
  AST_ADDR_FIXED: assert property ((stack_wr_ff || stack_rd_ff) |-> stack_addr_ff[15:7] == STACK_UPPER_BITS)
    else $error("stack address outside stack");
  AST_IRQ_FIVE: assert property (irq_take_ff |=> save_burst)
    else $error("context save not five bytes");
  AST_TAKE_BUSY: assert property (irq_take_ff |-> ctx_busy_ff)
    else $error("entry without busy");
  AST_TAKE_PULSE: assert property (irq_take_ff |=> !irq_take_ff [*6])
    else $error("nested entry during save");
  AST_PUSH_DEC: assert property (stack_wr_ff && $past(stack_wr_ff)
    |-> stack_addr_ff[6:0] == $past(stack_addr_ff[6:0]) - 7'h01)
    else $error("push address not decremented");
  AST_POP_INC: assert property (stack_rd_ff && $past(stack_rd_ff)
    |-> stack_addr_ff[6:0] == $past(stack_addr_ff[6:0]) + 7'h01)
    else $error("pop address not incremented");
  AST_WR_RD_EXCL: assert property (stack_wr_ff |-> !stack_rd_ff)
    else $error("read and write together");
  AST_RSP: assert property (stack_op == STK_RESETSP && !ctx_busy_ff |-> next_free_top)
    else $error("stack pointer not reloaded");
  AST_CARRY_SET: assert property (carry_set_instr && !alu_valid && !ctx_busy_ff
    |-> ##[1:2] condition_flags_ff[0])
    else $error("carry not set");
endmodule

bind cpu_register_set_flags_stack cpu_regs_chk cpu_regs_chk_i (.*);

//--- tb/stack_mem.sv
`timescale 1ns/1ps
module stack_mem (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // strobes from the register set
  input wire logic        stack_wr_ff,
  input wire logic        stack_rd_ff,
  input wire logic [15:0] stack_addr_ff,
  input wire logic [7:0]  stack_wr_data_ff,
  output logic [7:0]      stack_rd_data
);
  logic [7:0] mem [128];
  logic [7:0] junk_ff;

  // writes land on the edge; filler toggles so a late or early load shows
  always_ff @(posedge ref_clk) begin
    if (stack_wr_ff)
      mem[stack_addr_ff[6:0]] <= stack_wr_data_ff;
    if (reset)
      junk_ff <= 8'h5A;
    else
      junk_ff <= ~junk_ff;
  end

  // the register set loads pop data on the edge that ends its read strobe,
  // so the byte must stand while the strobe is high
  assign stack_rd_data = stack_rd_ff ? mem[stack_addr_ff[6:0]] : junk_ff;
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import cpu_regs_pkg::*;
  logic ref_clk = 0, reset = 1, wr_en = 0, pc_load = 0, pc_inc = 0, irq_req = 0;
  logic alu_valid = 0, alu_upd_nz = 0, alu_upd_half = 0, alu_half = 0, alu_upd_carry = 0, alu_carry = 0;
  logic mask_set_instr = 0, mask_clear_instr = 0, carry_set_instr = 0, carry_clear_instr = 0;
  reg_sel_t wr_sel = SEL_ACC, stack_sel = SEL_ACC;
  stack_op_t stack_op = STK_NONE;
  logic [7:0] wr_data = 0, alu_result = 0, stack_rd_data, stack_wr_data_ff, saved_f;
  logic [7:0] accumulator_ff, index_first_ff, index_second_ff, condition_flags_ff;
  logic [15:0] pc_load_val = 0, stack_addr_ff, program_counter_ff, stack_pointer_ff;
  logic stack_wr_ff, stack_rd_ff, ctx_busy_ff, irq_take_ff;
  int fail_count = 0, checks = 0, takes = 0;

  always #4 ref_clk = ~ref_clk;
  cpu_register_set_flags_stack cpu_register_set_flags_stack_i (.*);
  stack_mem stack_mem_i (.*);

  // entries counted apart from the scenarios so a missed pulse is not lost
  always @(posedge ref_clk)
    if (irq_take_ff === 1'b1)
      takes++;

  task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // inputs change by non-blocking assignment on the edge; reads see pre-edge values
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wreg(reg_sel_t s, logic [7:0] d);
    wr_sel <= s;
    wr_data <= d;
    wr_en <= 1'b1;
    tick(1);
    wr_en <= 1'b0;
    tick(3);
  endtask
  task automatic sop(stack_op_t o, reg_sel_t s);
    stack_op <= o;
    stack_sel <= s;
    tick(1);
  endtask
  task automatic idle(int n);
    stack_op <= STK_NONE;
    tick(n);
  endtask
  task automatic alu(logic [7:0] r, logic h, logic c);
    {alu_valid, alu_upd_nz, alu_upd_half, alu_upd_carry} <= 4'hF;
    {alu_result, alu_half, alu_carry} <= {r, h, c};
    tick(1);
    alu_valid <= 1'b0;
    tick(3);
    chk("acc", accumulator_ff, r);
    chk("flags", condition_flags_ff[4:0], {h, 1'b1, r[7], r == 8'h00, c});
  endtask

  task automatic t_regs;
    chk("reset_flags", {condition_flags_ff[7:5], condition_flags_ff[3]}, 4'hF);
    chk("reset_sp", stack_pointer_ff, STACK_RESET_VAL);
    wreg(SEL_IDX1, 8'h3C);
    wreg(SEL_IDX2, 8'hC3);
    wreg(SEL_SPL, 8'hD5);
    chk("idx", {index_first_ff, index_second_ff}, 16'h3CC3);
    chk("spl", stack_pointer_ff, 16'h01D5);
    pc_load_val <= 16'h12FF;
    pc_load <= 1'b1;
    tick(1);
    {pc_load, pc_inc} <= 2'b01;
    tick(1);
    pc_inc <= 1'b0;
    tick(2);
    chk("pc", program_counter_ff, 16'h1300);
    $display("test regs done");
  endtask

  task automatic t_alu;
    alu(8'h00, 1'b1, 1'b0);
    alu(8'h81, 1'b0, 1'b1);
    carry_clear_instr <= 1'b1;
    tick(1);
    {carry_clear_instr, carry_set_instr} <= 2'b01;
    tick(1);
    carry_set_instr <= 1'b0;
    tick(3);
    chk("carry", condition_flags_ff[0], 1'b1);
    $display("test alu done");
  endtask

  task automatic t_stack;
    sop(STK_RESETSP, SEL_ACC);
    idle(3);
    sop(STK_PUSH, SEL_ACC);
    sop(STK_PUSH, SEL_IDX1);
    sop(STK_PUSH, SEL_FLAGS);
    idle(4);
    chk("sp3", stack_pointer_ff, 16'h01FC);
    chk("mem3", {stack_mem_i.mem[127], stack_mem_i.mem[126]}, 16'h813C);
    chk("memf", stack_mem_i.mem[125], condition_flags_ff);
    saved_f = condition_flags_ff;
    carry_clear_instr <= 1'b1;
    tick(1);
    carry_clear_instr <= 1'b0;
    wreg(SEL_ACC, 8'h00);
    sop(STK_POP, SEL_FLAGS);
    sop(STK_POP, SEL_IDX2);
    sop(STK_POP, SEL_ACC);
    idle(5);
    chk("popf", condition_flags_ff, saved_f);
    chk("pops", {index_second_ff, accumulator_ff}, 16'h3C81);
    chk("sp0", stack_pointer_ff, STACK_RESET_VAL);
    wreg(SEL_SPL, 8'h00);
    sop(STK_PUSH, SEL_ACC);
    idle(4);
    chk("wrap", {stack_pointer_ff, stack_mem_i.mem[0]}, 24'h01FF81);
    sop(STK_POP, SEL_IDX2);
    idle(5);
    chk("unwrap", {stack_pointer_ff, index_second_ff}, 24'h018081);
    sop(STK_RESETSP, SEL_ACC);
    idle(3);
    $display("test stack done");
  endtask

  task automatic t_irq;
    irq_req <= 1'b1;
    tick(1);
    irq_req <= 1'b0;
    tick(8);
    chk("masked", takes, 0);
    mask_clear_instr <= 1'b1;
    tick(1);
    mask_clear_instr <= 1'b0;
    tick(2);
    saved_f = condition_flags_ff;
    tick(10);
    chk("taken", takes, 1);
    chk("ctx", {stack_mem_i.mem[127], stack_mem_i.mem[126]}, 16'h0013);
    chk("ctx2", {stack_mem_i.mem[125], stack_mem_i.mem[124]}, 16'h3C81);
    chk("ctxf", stack_mem_i.mem[123], saved_f);
    chk("sp5", stack_pointer_ff, 16'h01FA);
    chk("mask", condition_flags_ff[3], 1'b1);
    wreg(SEL_ACC, 8'hEE);
    wreg(SEL_IDX2, 8'h99);
    sop(STK_INTERRUPT_RETURN_INSTR, SEL_ACC);
    idle(12);
    chk("ret", {accumulator_ff, condition_flags_ff}, {8'h81, saved_f});
    chk("idx2", index_second_ff, 8'h99);
    chk("retctx", {index_first_ff, program_counter_ff}, 24'h3C1300);
    chk("retsp", stack_pointer_ff, STACK_RESET_VAL);
    $display("test irq done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog, well beyond the roughly 130 cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    wrap_up();
  end

  initial begin
    tick(16);
    reset <= 1'b0;
    tick(2);
    t_regs();
    t_alu();
    t_stack();
    t_irq();
    wrap_up();
  end
endmodule
